// [core/lfi_pkg.sv]
// constants and types for the flame and status led indicator
// Notes on behaviour
// - two separate led outputs are driven, one for flame sensing and one for system status.
// - the heartbeat alternates half a second bright and half a second dim with no pause.
// - a single code x is x pulses at 2 hz, then two seconds off, repeated.
// - a normal flame signal shows the heartbeat on the flame led.
// - a weak but adequate flame signal shows code 2 on the flame led.
// - a marginal flame signal shows code 1 on the flame led.
// - a flame signal below the operating minimum holds the flame led steadily off.
// - the status led is off with no heat demand, fast during calibration, heartbeat in run.
// - a failed pilot trial shows code 2 on the status led while a five minute delay runs.
// - when the five minute delay expires a new trial starts and the retry code is left.
// - a code x+y is x pulses, two seconds off, y pulses, three seconds off, repeated.
`default_nettype none

package lfi_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned TICK_NS        = 125_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W         = 25;
    localparam int unsigned TICKS_PER_S    = 8;
    localparam int unsigned PULSE_HZ       = 2;
    localparam int unsigned PULSE_TICKS    = TICKS_PER_S / (2 * PULSE_HZ);
    localparam int unsigned HEART_TICKS    = TICKS_PER_S / 2;
    localparam int unsigned GAP1_S         = 2;
    localparam int unsigned GAP2_S         = 3;
    localparam int unsigned GAP1_TICKS     = GAP1_S * TICKS_PER_S;
    localparam int unsigned GAP2_TICKS     = GAP2_S * TICKS_PER_S;
    localparam int unsigned RETRY_S        = 300;
    localparam int unsigned RETRY_TICKS    = RETRY_S * TICKS_PER_S;
    localparam int unsigned TCNT_W         = 5;
    localparam int unsigned CODE_W         = 4;
    localparam int unsigned RETRY_W        = 12;
    localparam logic [3:0]  WEAK_CODE      = 4'h2;
    localparam logic [3:0]  MARGINAL_CODE  = 4'h1;
    localparam logic [3:0]  RETRY_CODE     = 4'h2;
    localparam logic [3:0]  NO_CODE        = 4'h0;

    typedef enum logic [1:0] {FL_NONE, FL_MARGINAL, FL_WEAK, FL_NORMAL} lfi_flame_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CALIB, ST_RUN, ST_CODE} lfi_status_t;
    typedef enum logic [1:0] {PAT_OFF, PAT_FAST, PAT_HEART, PAT_CODE} lfi_pat_t;
    typedef enum logic [2:0] {SEG_A_ON, SEG_A_OFF, SEG_A_GAP,
                              SEG_B_ON, SEG_B_OFF, SEG_B_GAP} lfi_seg_t;
endpackage : lfi_pkg

`default_nettype wire

// [core/lfi_indicator.sv]
// led pattern generator and the two-led indicator top with retry delay timer
`timescale 1ns/10ps
`default_nettype none

module lfi_led_pattern (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   tick,
    input  wire lfi_pkg::lfi_pat_t      pat,
    input  wire logic [lfi_pkg::CODE_W-1:0] code_x,
    input  wire logic [lfi_pkg::CODE_W-1:0] code_y,
    output logic                        led
);
    import lfi_pkg::*;

    lfi_pat_t              pat_q_r;
    logic [CODE_W-1:0]     x_q_r;
    logic [CODE_W-1:0]     y_q_r;
    lfi_seg_t              seg_r;
    lfi_seg_t              seg_nxt;
    logic [TCNT_W-1:0]     tcnt_r;
    logic [TCNT_W-1:0]     tcnt_nxt;
    logic [CODE_W-1:0]     pcnt_r;
    logic [CODE_W-1:0]     pcnt_nxt;
    logic [1:0]            pwm_r;
    logic                  led_nxt;

    function automatic logic [TCNT_W-1:0] seg_len(input lfi_seg_t s);
        case (s)
            SEG_A_GAP: seg_len = TCNT_W'(GAP1_TICKS);
            SEG_B_GAP: seg_len = TCNT_W'(GAP2_TICKS);
            default:   seg_len = TCNT_W'(PULSE_TICKS);
        endcase
    endfunction : seg_len

    wire               sel_change = (pat != pat_q_r) || (code_x != x_q_r) || (code_y != y_q_r);
    wire               seg_end    = (tcnt_r == seg_len(seg_r) - TCNT_W'(1));
    wire [CODE_W-1:0]  pcnt_inc   = pcnt_r + CODE_W'(1);
    wire               cyc_pat    = (pat == PAT_HEART) || (pat == PAT_FAST);
    // dim phase is a quarter duty so the led stays visibly lit
    wire               dim        = (pwm_r == 2'h0);

    always_comb begin
        seg_nxt  = seg_r;
        tcnt_nxt = tcnt_r;
        pcnt_nxt = pcnt_r;
        if (sel_change) begin
            seg_nxt  = SEG_A_ON;
            tcnt_nxt = '0;
            pcnt_nxt = '0;
        end else if (tick && cyc_pat) begin
            tcnt_nxt = (tcnt_r + TCNT_W'(1)) & TCNT_W'(2 * HEART_TICKS - 1);
        end else if (tick && seg_end) begin
            tcnt_nxt = '0;
            case (seg_r)
                SEG_A_ON: begin
                    seg_nxt = (pcnt_inc == code_x) ? SEG_A_GAP : SEG_A_OFF;
                    pcnt_nxt = pcnt_inc;
                end
                SEG_A_OFF: seg_nxt = SEG_A_ON;
                SEG_A_GAP: begin
                    seg_nxt  = (code_y != NO_CODE) ? SEG_B_ON : SEG_A_ON;
                    pcnt_nxt = '0;
                end
                SEG_B_ON: begin
                    seg_nxt = (pcnt_inc == code_y) ? SEG_B_GAP : SEG_B_OFF;
                    pcnt_nxt = pcnt_inc;
                end
                SEG_B_OFF: seg_nxt = SEG_B_ON;
                SEG_B_GAP: begin
                    seg_nxt  = SEG_A_ON;
                    pcnt_nxt = '0;
                end
                default: seg_nxt = SEG_A_ON;
            endcase
        end else if (tick) begin
            tcnt_nxt = tcnt_r + TCNT_W'(1);
        end
    end

    always_comb begin
        case (pat)
            PAT_FAST:  led_nxt = tcnt_nxt[0];
            PAT_HEART: led_nxt = (tcnt_nxt < TCNT_W'(HEART_TICKS)) || dim;
            PAT_CODE:  led_nxt = (code_x != NO_CODE) &&
                                 ((seg_nxt == SEG_A_ON) || (seg_nxt == SEG_B_ON));
            default:   led_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pat_q_r <= PAT_OFF;
            x_q_r   <= '0;
            y_q_r   <= '0;
            seg_r   <= SEG_A_ON;
            tcnt_r  <= '0;
            pcnt_r  <= '0;
            pwm_r   <= '0;
            led     <= 1'b0;
        end else begin
            pat_q_r <= pat;
            x_q_r   <= code_x;
            y_q_r   <= code_y;
            seg_r   <= seg_nxt;
            tcnt_r  <= tcnt_nxt;
            pcnt_r  <= pcnt_nxt;
            pwm_r   <= pwm_r + 2'h1;
            led     <= led_nxt;
        end
    end

    localparam int unsigned P_LAST = PULSE_TICKS - 1;
    localparam int unsigned G_LAST = GAP1_TICKS - 1;

    default clocking pcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_restart_first_pulse: assert property (sel_change |=> seg_r == SEG_A_ON && tcnt_r == 0)
        else $error("pattern did not restart on code change");
    a_heart_bright_phase: assert property (pat_q_r == PAT_HEART && tcnt_r < HEART_TICKS |-> led)
        else $error("heartbeat bright phase not lit");
    a_pulse_width_end: assert property (pat == PAT_CODE && !sel_change && seg_r == SEG_A_ON
                                        && tick && tcnt_r == P_LAST |=> seg_r != SEG_A_ON)
        else $error("code pulse longer than quarter second");
    a_second_group_start: assert property (pat == PAT_CODE && !sel_change && seg_r == SEG_A_GAP
                                           && code_y != 0 && tick && tcnt_r == G_LAST
                                           |=> seg_r == SEG_B_ON)
        else $error("second group did not follow first gap");
    c_second_gap: cover property (seg_r == SEG_B_GAP && tick);
    c_heartbeat_wrap: cover property (pat_q_r == PAT_HEART && tcnt_r == 7 && tick);
endmodule : lfi_led_pattern

module lfi_indicator #(
    parameter int unsigned TICK_CYCLES = lfi_pkg::TICK_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire lfi_pkg::lfi_flame_t    flame_class,
    input  wire lfi_pkg::lfi_status_t   status_mode,
    input  wire logic [lfi_pkg::CODE_W-1:0] status_x,
    input  wire logic [lfi_pkg::CODE_W-1:0] status_y,
    input  wire logic                   retry_start,
    output logic                        flame_led,
    output logic                        status_led,
    output logic                        retry_active,
    output logic                        new_trial
);
    import lfi_pkg::*;

    logic [TICK_W-1:0]   tick_cnt_r;
    logic                tick_r;
    logic [RETRY_W-1:0]  retry_cnt_r;
    logic                retry_active_r;
    logic                new_trial_r;

    wire                 tick_wrap   = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
    wire                 retry_go    = retry_start && !retry_active_r;
    wire                 retry_done  = retry_active_r && tick_r &&
                                       (retry_cnt_r == RETRY_W'(RETRY_TICKS - 1));

    // flame led depends on flame class only; status led never sees it
    lfi_pat_t            flame_pat;
    wire [CODE_W-1:0]    flame_x;
    assign flame_pat = (flame_class == FL_NORMAL) ? PAT_HEART :
                       (flame_class == FL_NONE)   ? PAT_OFF : PAT_CODE;
    assign flame_x   = (flame_class == FL_WEAK)     ? WEAK_CODE :
                       (flame_class == FL_MARGINAL) ? MARGINAL_CODE : NO_CODE;

    lfi_pat_t            status_pat;
    wire [CODE_W-1:0]    stat_x;
    wire [CODE_W-1:0]    stat_y;
    assign status_pat = retry_active_r          ? PAT_CODE :
                        (status_mode == ST_IDLE)  ? PAT_OFF :
                        (status_mode == ST_CALIB) ? PAT_FAST :
                        (status_mode == ST_RUN)   ? PAT_HEART : PAT_CODE;
    assign stat_x = retry_active_r ? RETRY_CODE : status_x;
    assign stat_y = retry_active_r ? NO_CODE : status_y;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
            tick_r     <= tick_wrap;
        end
    end

    // a retry request during a running delay is ignored, not restarted
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt_r    <= '0;
            retry_active_r <= 1'b0;
            new_trial_r    <= 1'b0;
        end else begin
            if (retry_go) begin
                retry_cnt_r <= '0;
            end else if (retry_active_r && tick_r) begin
                retry_cnt_r <= retry_cnt_r + RETRY_W'(1);
            end
            retry_active_r <= retry_go || (retry_active_r && !retry_done);
            new_trial_r    <= retry_done;
        end
    end

    assign retry_active = retry_active_r;
    assign new_trial    = new_trial_r;

    lfi_led_pattern u_flame (
        .clk    (core_clk),
        .rst_n  (rst_n),
        .tick   (tick_r),
        .pat    (flame_pat),
        .code_x (flame_x),
        .code_y (NO_CODE),
        .led    (flame_led)
    );

    lfi_led_pattern u_status (
        .clk    (core_clk),
        .rst_n  (rst_n),
        .tick   (tick_r),
        .pat    (status_pat),
        .code_x (stat_x),
        .code_y (stat_y),
        .led    (status_led)
    );

    default clocking icb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_flame_off_steady: assert property (flame_class == FL_NONE |=> !flame_led)
        else $error("flame led lit below minimum flame");
    a_leds_kept_apart: assert property (flame_class == FL_NONE && status_mode == ST_RUN
                                        && !retry_active_r |=> !flame_led)
        else $error("status pattern leaked onto flame led");
    a_flame_normal_heart: assert property (flame_class == FL_NORMAL |-> flame_pat == PAT_HEART)
        else $error("normal flame not shown as heartbeat");
    a_flame_weak_code: assert property (flame_class == FL_WEAK
                                        |-> flame_pat == PAT_CODE && flame_x == 4'h2)
        else $error("weak flame not shown as code 2");
    a_flame_marginal_code: assert property (flame_class == FL_MARGINAL
                                            |-> flame_pat == PAT_CODE && flame_x == 4'h1)
        else $error("marginal flame not shown as code 1");
    a_status_idle_off: assert property (status_mode == ST_IDLE && !retry_active_r
                                        |=> !status_led)
        else $error("status led lit with no heat demand");
    a_retry_starts_code: assert property (retry_start && !retry_active_r
                                          |=> retry_active && status_pat == PAT_CODE
                                              && stat_x == 4'h2 && stat_y == 4'h0)
        else $error("retry delay did not show code 2");
    a_retry_expiry_trial: assert property (new_trial |-> !retry_active && $past(retry_active))
        else $error("new trial without an expiring retry delay");
    c_retry_expired: cover property (new_trial);
    c_status_calib: cover property (status_mode == ST_CALIB && status_led);
    c_flame_weak_lit: cover property (flame_class == FL_WEAK && flame_led);
endmodule : lfi_indicator

`default_nettype wire

// [verification/lfi_led_viewer.sv]
// technician's eye on one led: run lengths and lit-cycle count
`timescale 1ns/10ps
`default_nettype none

module lfi_led_viewer (
    input  wire logic clk,
    input  wire logic clear,
    input  wire logic led
);
    // runs hold +len for lit stretches and -len for dark ones, in clocks
    int   runs[$];
    int   highs;
    int   len;
    logic prev;

    always @(posedge clk) begin
        if (clear) begin
            runs.delete();
            highs = 0;
            len = 0;
            prev = led;
        end else begin
            if (led) highs++;
            if (led !== prev && len > 0) begin
                runs.push_back(prev ? len : -len);
                len = 0;
            end
            len++;
            prev = led;
        end
    end
endmodule : lfi_led_viewer

`default_nettype wire

// [verification/lfi_indicator_test.sv]
// self-checking bench for the flame and status indicator
`timescale 1ns/10ps
`default_nettype none

module lfi_indicator_test;
    import lfi_pkg::*;
    localparam int TCK = 4;
    logic              core_clk = 1'h0;
    logic              rst_n = 1'h0;
    lfi_flame_t        flame_class = FL_NONE;
    lfi_status_t       status_mode = ST_IDLE;
    logic [CODE_W-1:0] status_x = 4'h0;
    logic [CODE_W-1:0] status_y = 4'h0;
    logic              retry_start = 1'h0;
    logic              clear = 1'h0;
    logic              flame_led, status_led, retry_active, new_trial;
    int                failures = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    int                n;
    int                q[$];
    int                rx;
    int                ry;

    always #2 core_clk = ~core_clk;

    lfi_indicator #(.TICK_CYCLES(TCK)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .flame_class(flame_class), .status_mode(status_mode), .status_x(status_x),
        .status_y(status_y), .retry_start(retry_start), .flame_led(flame_led),
        .status_led(status_led), .retry_active(retry_active), .new_trial(new_trial));
    lfi_led_viewer i_flame_view (.clk(core_clk), .clear(clear), .led(flame_led));
    lfi_led_viewer i_stat_view (.clk(core_clk), .clear(clear), .led(status_led));

    // signed so that dark run lengths print as negative numbers
    task automatic check(input string what, input logic signed [31:0] seen,
                         input logic signed [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // expected runs of two whole periods of code x (+y), first pulse included
    function automatic void build(input int x, input int y);
        q.delete();
        repeat (2) begin
            for (int i = 1; i <= x; i++) begin
                q.push_back(2 * TCK);
                q.push_back(i == x ? -16 * TCK : -2 * TCK);
            end
            for (int i = 1; i <= y; i++) begin
                q.push_back(2 * TCK);
                q.push_back(i == y ? -24 * TCK : -2 * TCK);
            end
        end
    endfunction : build

    // first run is skipped: the free-running tick may shorten it
    task automatic cmp_runs(input logic sel, input int x, input int y);
        int got;
        build(x, y);
        for (int k = 1; k < q.size(); k++) begin
            got = sel ? i_stat_view.runs[k] : i_flame_view.runs[k];
            check("run length", got, q[k]);
        end
    endtask : cmp_runs

    task automatic apply(input lfi_flame_t f, input lfi_status_t s, input int x, input int y);
        @(posedge core_clk);
        flame_class <= f;
        status_mode <= s;
        status_x <= x[CODE_W-1:0];
        status_y <= y[CODE_W-1:0];
        clear <= 1'h1;
        @(posedge core_clk);
        clear <= 1'h0;
        #1;
    endtask : apply

    task automatic code_test(input string name, input logic sel, input lfi_flame_t f,
                             input lfi_status_t s, input int x, input int y);
        int total;
        apply(f, s, x, y);
        check("first pulse", sel ? status_led : flame_led, 1);
        build(x, y);
        total = 16;
        foreach (q[k]) total += (q[k] < 0) ? -q[k] : q[k];
        repeat (total) @(posedge core_clk);
        cmp_runs(sel, x, y);
        $display("test %s done", name);
    endtask : code_test

    // lit cycles over 64 clocks: two heartbeat periods or eight fast periods
    task automatic count_test(input string name, input logic sel, input lfi_flame_t f,
                              input lfi_status_t s, input int exp);
        apply(f, s, 0, 0);
        repeat (40) @(posedge core_clk);
        clear <= 1'h1;
        @(posedge core_clk);
        clear <= 1'h0;
        repeat (64) @(posedge core_clk);
        #1;
        check("lit cycles", sel ? i_stat_view.highs : i_flame_view.highs, exp);
        $display("test %s done", name);
    endtask : count_test

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            end_of_test;
        end
    end

    initial begin
        void'($urandom(61389));
        repeat (12) @(posedge core_clk);
        rst_n <= 1'h1;
        count_test("flame normal", 0, FL_NORMAL, ST_IDLE, 40);
        code_test("flame weak", 0, FL_WEAK, ST_IDLE, WEAK_CODE, 0);
        code_test("flame marginal", 0, FL_MARGINAL, ST_IDLE, MARGINAL_CODE, 0);
        count_test("flame none", 0, FL_NONE, ST_RUN, 0);
        count_test("status idle", 1, FL_NORMAL, ST_IDLE, 0);
        count_test("status calib", 1, FL_NONE, ST_CALIB, 32);
        count_test("status run", 1, FL_WEAK, ST_RUN, 40);
        for (int i = 0; i < 2; i++) begin
            rx = 1 + $urandom % 3;
            ry = 1 + $urandom % 3;
            // a repeat of the last code would not restart the pattern
            if (rx == status_x && ry == status_y) rx = rx % 3 + 1;
            code_test("status code", 1, FL_NORMAL, ST_CODE, rx, ry);
        end
        count_test("status run again", 1, FL_NORMAL, ST_RUN, 40);
        @(posedge core_clk);
        retry_start <= 1'h1;
        clear <= 1'h1;
        @(posedge core_clk);
        retry_start <= 1'h0;
        // clear held one more clock so the viewer starts on the retry code itself
        #1 check("retry active", retry_active, 1);
        n = 0;
        while (retry_active === 1'h1 && n < 20000) begin
            @(posedge core_clk);
            retry_start <= (n == 5000);
            clear <= 1'h0;
            #1 n++;
            if (n == 3000) cmp_runs(1, RETRY_CODE, 0);
        end
        check("new trial", new_trial, 1);
        check("delay in range", n >= (RETRY_TICKS - 1) * TCK && n <= (RETRY_TICKS + 1) * TCK, 1);
        @(posedge core_clk);
        #1 check("new trial pulse", new_trial, 0);
        $display("test retry delay done");
        count_test("after retry", 1, FL_NORMAL, ST_RUN, 40);
        end_of_test;
    end
endmodule : lfi_indicator_test

`default_nettype wire
